// ==== src/swsc_map.svh ====
/*
 * constants of the single-wire sensor command layer: command codes, bit counts,
 * reset values, crc polynomial and timing counts.
 * assumes a 20 MHz sys_clk and a bit-slot layer that delivers whole slots.
 */
// Operation
// - reset and presence precede every addressing command
// - read identity shifts out all 64 bits
// - match: act only if all 64 bits equal
// - join search; host resets after each pass
// - skip: next function command needs no identity
// - alarm search: join only while alarm set
// - alarm set outside thresholds, cleared inside
// - write: two bytes lsb first, upper then lower
// - read: eight register bytes then crc byte
// - reset pulse abandons read, acts as reset
// - convert command starts one conversion, stores result
// - read slots show 0 busy, 1 done
// - power query returns ff normal, 00 parasitic
// - recall loads thresholds; slots show 0 then 1
// - power-up loads registers from nonvolatile store
// - copy saves both thresholds to nonvolatile store
// - reload restores every register like power-on
// - crc x8+x5+x4+1, zero start, lsb first
// - register crc tracks stored bytes, residue zero
// - identity: family, 48-bit serial, crc of 56
`ifndef SWSC_MAP_SVH
`define SWSC_MAP_SVH

// ----------------------------------------------------------------
// command codes
// ----------------------------------------------------------------
`define SWSC_CMD_READ_ID 8'h33
`define SWSC_CMD_MATCH 8'h55
`define SWSC_CMD_SEARCH 8'hf0
`define SWSC_CMD_SKIP 8'hcc
`define SWSC_CMD_ALARM_SEARCH 8'hec
`define SWSC_CMD_WRITE_REG 8'h4e
`define SWSC_CMD_READ_REG 8'hbe
`define SWSC_CMD_CONVERT 8'h44
`define SWSC_CMD_READ_POWER 8'hb4
`define SWSC_CMD_RECALL 8'hb8
`define SWSC_CMD_COPY 8'h48
`define SWSC_CMD_RELOAD 8'hc7

// ----------------------------------------------------------------
// bit counts (last index of each transfer)
// ----------------------------------------------------------------
`define SWSC_BYTE_LAST 7'h07
`define SWSC_WR_LAST 7'h0f
`define SWSC_ID_LAST 7'h3f
`define SWSC_REG_LAST 7'h47

// ----------------------------------------------------------------
// reset values and answers
// ----------------------------------------------------------------
`define SWSC_TEMP_RST 16'h0550
`define SWSC_TH_RST 8'h55
`define SWSC_TL_RST 8'h00
`define SWSC_CFG_RST 8'h7f
`define SWSC_RES0_RST 8'h00
`define SWSC_RES1_RST 8'h00
`define SWSC_RES2_RST 8'hff
`define SWSC_PWR_NORMAL 1'h1
`define SWSC_PWR_PARASITIC 1'h0
`define SWSC_CRC_POLY 8'h8c
`define SWSC_CRC_INIT 8'h00

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define SWSC_CLK_NS 50
`define SWSC_RECALL_US 10
`define SWSC_RECALL_CYC (8'((`SWSC_RECALL_US * 1000 + `SWSC_CLK_NS - 1) / `SWSC_CLK_NS))

`endif

// ==== src/swsc_pkg.sv ====
/*
 * types of the single-wire sensor command layer.
 * assumes swsc_map.svh for every numeric constant.
 */
package swsc_pkg;

	// ----------------------------------------------------------------
	// sequencer states
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		ST_WAIT = 4'h0,
		ST_ROM = 4'h1,
		ST_RDID = 4'h2,
		ST_MATCH = 4'h3,
		ST_SRCH = 4'h4,
		ST_FUNC = 4'h5,
		ST_WRS = 4'h6,
		ST_RDS = 4'h7,
		ST_CONV = 4'h8,
		ST_RCL = 4'h9,
		ST_PWR = 4'ha,
		ST_QUIET = 4'hb
	} swsc_state_t;

	// ----------------------------------------------------------------
	// slot events from the bit-slot layer, answer back to it
	// ----------------------------------------------------------------
	typedef struct packed {
		logic reset;
		logic wr;
		logic rd;
		logic bit_val;
	} swsc_slot_t;

	typedef struct packed {
		logic drive;
		logic bit_val;
	} swsc_ans_t;

endpackage

// ==== src/swsc_crc8.sv ====
/*
 * combinational 8-bit crc over a fixed-length word, bit 0 fed first.
 * assumes the word is stable; the result follows it without a clock.
 */
`timescale 1ns/1ps
`include "swsc_map.svh"

module swsc_crc8 #(
	parameter int NBITS = 64
) (
	// data in
	input wire logic [NBITS-1:0] data,
	// crc out
	output logic [7:0] crc
);

	// ----------------------------------------------------------------
	// reflected form: right shift with polynomial 8c equals x8+x5+x4+1
	// ----------------------------------------------------------------
	always_comb begin
		logic fb;
		fb = 1'b0;
		crc = `SWSC_CRC_INIT;
		for (int i = 0; i < NBITS; i++) begin
			fb = crc[0] ^ data[i];
			crc = {1'b0, crc[7:1]} ^ (fb ? `SWSC_CRC_POLY : 8'h00);
		end
	end

endmodule

// ==== src/swsc_cmd.sv ====
/*
 * command layer of a single-wire temperature sensor slave: addressing,
 * search, function commands, scratch registers, nonvolatile store and crc.
 * assumes a bit-slot layer that turns bus timing into one-cycle slot events
 * and drives the open-drain pin from the answer; a converter outside.
 */
`timescale 1ns/1ps
`include "swsc_map.svh"

module swsc_cmd
	import swsc_pkg::*;
#(
	parameter logic [7:0] FAMILY_CODE = 8'h5a, // arbitrary value
	parameter logic [47:0] SERIAL_NUM = 48'h0123_4567_89ab // arbitrary value
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// slot events from the bit-slot layer
	input wire swsc_slot_t slot,
	// answer for read slots
	output swsc_ans_t ans_q,
	// converter
	output logic conv_start_q,
	input wire logic conv_done,
	input wire logic [15:0] conv_temp,
	// supply sense and status
	input wire logic parasitic_pwr,
	output logic alarm_q
);

	// ----------------------------------------------------------------
	// storage
	// ----------------------------------------------------------------
	swsc_state_t state_q;
	logic [6:0] cnt_q;
	logic [1:0] sub_q;
	logic [7:0] cmd_q;
	logic miss_q;
	logic [15:0] temp_q;
	logic [7:0] upper_alarm_threshold_q;
	logic [7:0] lower_alarm_threshold_q;
	logic [7:0] nv_upper_q;
	logic [7:0] nv_lower_q;
	logic [7:0] wbuf_q;
	logic conv_busy_q;
	logic [7:0] rcl_cnt_q;
	logic boot_q;

	logic [7:0] cmd_d;
	logic [63:0] unique_identity_code;
	logic [7:0] id_crc;
	logic [71:0] reg_image;
	logic [7:0] reg_crc;
	logic own_bit;
	logic byte_done;
	logic func_take;
	logic nv_load;
	swsc_ans_t ans_d;

	// ----------------------------------------------------------------
	// identity and register image
	// ----------------------------------------------------------------
	swsc_crc8 #(.NBITS(56)) u_id_crc (
		.data({SERIAL_NUM, FAMILY_CODE}),
		.crc(id_crc)
	);

	assign unique_identity_code = {id_crc, SERIAL_NUM, FAMILY_CODE};

	// fed from the stored bytes, not the image, so no loop runs through the crc byte
	swsc_crc8 #(.NBITS(64)) u_reg_crc (
		.data({`SWSC_RES2_RST, `SWSC_RES1_RST, `SWSC_RES0_RST, `SWSC_CFG_RST,
			lower_alarm_threshold_q, upper_alarm_threshold_q, temp_q}),
		.crc(reg_crc)
	);

	// crc is combinational on the stored bytes, so it never goes stale
	assign reg_image = {reg_crc, `SWSC_RES2_RST, `SWSC_RES1_RST, `SWSC_RES0_RST,
		`SWSC_CFG_RST, lower_alarm_threshold_q, upper_alarm_threshold_q, temp_q};

	function automatic logic take_byte(input logic [6:0] cnt, input logic wr);
		take_byte = wr && (cnt == `SWSC_BYTE_LAST);
	endfunction

	assign cmd_d = {slot.bit_val, cmd_q[7:1]};
	assign own_bit = unique_identity_code[cnt_q[5:0]];
	assign byte_done = take_byte(cnt_q, slot.wr);
	assign func_take = (state_q == ST_FUNC) && byte_done && !slot.reset;

	// ----------------------------------------------------------------
	// command sequencer
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			state_q <= ST_WAIT;
			cnt_q <= 7'h00;
			sub_q <= 2'h0;
			cmd_q <= 8'h00;
			miss_q <= 1'b0;
			wbuf_q <= 8'h00;
		end else if (slot.reset) begin
			// a reset pulse ends whatever transfer was under way; a running conversion or recall goes on
			state_q <= ST_ROM;
			cnt_q <= 7'h00;
			sub_q <= 2'h0;
			miss_q <= 1'b0;
		end else begin
			case (state_q)
				ST_ROM: begin
					if (slot.wr) begin
						cmd_q <= cmd_d;
						cnt_q <= byte_done ? 7'h00 : cnt_q + 7'h01;
					end
					if (byte_done) begin
						case (cmd_d)
							`SWSC_CMD_READ_ID: state_q <= ST_RDID;
							`SWSC_CMD_MATCH: state_q <= ST_MATCH;
							`SWSC_CMD_SEARCH: state_q <= ST_SRCH;
							`SWSC_CMD_ALARM_SEARCH: state_q <= alarm_q ? ST_SRCH : ST_QUIET;
							`SWSC_CMD_SKIP: state_q <= ST_FUNC;
							default: state_q <= ST_QUIET;
						endcase
					end
				end
				ST_RDID: begin
					if (slot.rd) begin
						cnt_q <= (cnt_q == `SWSC_ID_LAST) ? 7'h00 : cnt_q + 7'h01;
						if (cnt_q == `SWSC_ID_LAST) begin
							state_q <= ST_FUNC;
						end
					end
				end
				ST_MATCH: begin
					if (slot.wr) begin
						cnt_q <= (cnt_q == `SWSC_ID_LAST) ? 7'h00 : cnt_q + 7'h01;
						miss_q <= miss_q | (slot.bit_val != own_bit);
						if (cnt_q == `SWSC_ID_LAST) begin
							// one wrong bit anywhere leaves the device passive
							state_q <= (miss_q | (slot.bit_val != own_bit)) ? ST_QUIET : ST_FUNC;
						end
					end
				end
				ST_SRCH: begin
					// per bit: read own bit, read its complement, take host choice
					if (slot.rd && sub_q != 2'h2) begin
						sub_q <= sub_q + 2'h1;
					end else if (slot.wr && sub_q == 2'h2) begin
						sub_q <= 2'h0;
						cnt_q <= cnt_q + 7'h01;
						if (slot.bit_val != own_bit || cnt_q == `SWSC_ID_LAST) begin
							// a finished pass waits for a fresh reset
							state_q <= ST_QUIET;
						end
					end
				end
				ST_FUNC: begin
					if (slot.wr) begin
						cmd_q <= cmd_d;
						cnt_q <= byte_done ? 7'h00 : cnt_q + 7'h01;
					end
					if (byte_done) begin
						case (cmd_d)
							`SWSC_CMD_WRITE_REG: state_q <= ST_WRS;
							`SWSC_CMD_READ_REG: state_q <= ST_RDS;
							`SWSC_CMD_CONVERT: state_q <= ST_CONV;
							`SWSC_CMD_READ_POWER: state_q <= ST_PWR;
							`SWSC_CMD_RECALL: state_q <= ST_RCL;
							default: state_q <= ST_QUIET;
						endcase
					end
				end
				ST_WRS: begin
					if (slot.wr) begin
						wbuf_q <= {slot.bit_val, wbuf_q[7:1]};
						cnt_q <= cnt_q + 7'h01;
						if (cnt_q == `SWSC_WR_LAST) begin
							state_q <= ST_QUIET;
						end
					end
				end
				ST_RDS: begin
					if (slot.rd) begin
						cnt_q <= cnt_q + 7'h01;
						if (cnt_q == `SWSC_REG_LAST) begin
							state_q <= ST_QUIET;
						end
					end
				end
				ST_PWR: begin
					if (slot.rd) begin
						cnt_q <= cnt_q + 7'h01;
						if (cnt_q == `SWSC_BYTE_LAST) begin
							state_q <= ST_QUIET;
						end
					end
				end
				ST_CONV, ST_RCL, ST_QUIET, ST_WAIT: begin
					state_q <= state_q;
				end
				default: begin
					state_q <= ST_QUIET;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// read slot answers
	// ----------------------------------------------------------------
	always_comb begin
		ans_d = '{drive: 1'b0, bit_val: 1'b1};
		case (state_q)
			ST_RDID: ans_d = '{drive: 1'b1, bit_val: own_bit};
			ST_SRCH: begin
				if (sub_q != 2'h2) begin
					ans_d = '{drive: 1'b1, bit_val: own_bit ^ sub_q[0]};
				end
			end
			ST_RDS: ans_d = '{drive: 1'b1, bit_val: reg_image[cnt_q]};
			ST_PWR: begin
				ans_d.drive = 1'b1;
				ans_d.bit_val = parasitic_pwr ? `SWSC_PWR_PARASITIC : `SWSC_PWR_NORMAL;
			end
			ST_CONV: ans_d = '{drive: 1'b1, bit_val: !conv_busy_q};
			ST_RCL: ans_d = '{drive: 1'b1, bit_val: rcl_cnt_q == 8'h00};
			default: ans_d = '{drive: 1'b0, bit_val: 1'b1};
		endcase
	end

	// answer is taken at the read slot and stands until the next read slot or reset
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			ans_q <= '{drive: 1'b0, bit_val: 1'b1};
		end else if (slot.reset) begin
			ans_q <= '{drive: 1'b0, bit_val: 1'b1};
		end else if (slot.rd) begin
			ans_q <= ans_d;
		end
	end

	// ----------------------------------------------------------------
	// conversion and alarm
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			conv_start_q <= 1'b0;
			conv_busy_q <= 1'b0;
		end else begin
			conv_start_q <= func_take && cmd_d == `SWSC_CMD_CONVERT;
			if (func_take && cmd_d == `SWSC_CMD_CONVERT) begin
				conv_busy_q <= 1'b1;
			end else if (conv_done) begin
				conv_busy_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			alarm_q <= 1'b0;
		end else if (conv_done) begin
			// whole degrees of the result against the signed thresholds
			alarm_q <= ($signed(conv_temp[11:4]) >= $signed(upper_alarm_threshold_q)) ||
				($signed(conv_temp[11:4]) < $signed(lower_alarm_threshold_q));
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			temp_q <= `SWSC_TEMP_RST;
		end else if (conv_done) begin
			temp_q <= conv_temp;
		end else if (func_take && cmd_d == `SWSC_CMD_RELOAD) begin
			temp_q <= `SWSC_TEMP_RST;
		end
	end

	// ----------------------------------------------------------------
	// thresholds and nonvolatile store
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			boot_q <= 1'b1;
			rcl_cnt_q <= 8'h00;
		end else begin
			boot_q <= 1'b0;
			if (func_take && cmd_d == `SWSC_CMD_RECALL) begin
				rcl_cnt_q <= `SWSC_RECALL_CYC;
			end else if (rcl_cnt_q != 8'h00) begin
				rcl_cnt_q <= rcl_cnt_q - 8'h01;
			end
		end
	end

	// power-up, reload and the end of a recall all copy the store out
	assign nv_load = boot_q || (rcl_cnt_q == 8'h01) ||
		(func_take && cmd_d == `SWSC_CMD_RELOAD);

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			upper_alarm_threshold_q <= `SWSC_TH_RST;
			lower_alarm_threshold_q <= `SWSC_TL_RST;
		end else if (nv_load) begin
			upper_alarm_threshold_q <= nv_upper_q;
			lower_alarm_threshold_q <= nv_lower_q;
		end else if (state_q == ST_WRS && !slot.reset && slot.wr) begin
			// each byte lands as soon as it is whole; a cut second byte is lost
			if (cnt_q == `SWSC_BYTE_LAST) begin
				upper_alarm_threshold_q <= {slot.bit_val, wbuf_q[7:1]};
			end
			if (cnt_q == `SWSC_WR_LAST) begin
				lower_alarm_threshold_q <= {slot.bit_val, wbuf_q[7:1]};
			end
		end
	end

	// the store model loses its content on rst, which stands for power removal
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			nv_upper_q <= `SWSC_TH_RST;
			nv_lower_q <= `SWSC_TL_RST;
		end else if (func_take && cmd_d == `SWSC_CMD_COPY) begin
			nv_upper_q <= upper_alarm_threshold_q;
			nv_lower_q <= lower_alarm_threshold_q;
		end
	end

endmodule

// ==== verif/swsc_cmd_properties.sv ====
/*
 * port checker of the command layer: answer timing, start pulse, alarm, busy slots.
 * assumes one clock with async active high rst; bound to every swsc_cmd.
 */
`timescale 1ns/1ps
module swsc_cmd_properties
	import swsc_pkg::*;
(
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// slot side
	input wire swsc_slot_t slot,
	input wire swsc_ans_t ans_q,
	// converter and status
	input wire logic conv_start_q,
	input wire logic conv_done,
	input wire logic [15:0] conv_temp,
	input wire logic parasitic_pwr,
	input wire logic alarm_q
);
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (rst);

	// ----------------------------------------------------------------
	// helper state
	// ----------------------------------------------------------------
	// a slot reset ends the phase, though the converter may still run
	logic busy_q;
	logic phase_q;
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst)
			busy_q <= 1'b0;
		else if (conv_start_q)
			busy_q <= 1'b1;
		else if (conv_done)
			busy_q <= 1'b0;
	end
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst)
			phase_q <= 1'b0;
		else if (slot.reset)
			phase_q <= 1'b0;
		else if (conv_start_q)
			phase_q <= 1'b1;
	end

	// ----------------------------------------------------------------
	// properties
	// ----------------------------------------------------------------
	sequence s_fresh;
		slot.reset ##1 (!slot.wr && !slot.reset)[*4];
	endsequence
	sequence s_busy_rd;
		phase_q && busy_q && !conv_done && slot.rd;
	endsequence
	sequence s_done_rd;
		phase_q && !busy_q && slot.rd;
	endsequence

	a_ans_reset_idle: assert property (slot.reset |=> ans_q == 2'b01)
		else $error("answer not released after slot reset");
	a_ans_holds_value: assert property ($changed(ans_q) |-> $past(slot) != 4'h0)
		else $error("answer changed without a slot");
	a_start_one_cycle: assert property (conv_start_q |=> !conv_start_q)
		else $error("start pulse longer than one cycle");
	a_start_after_write: assert property ($rose(conv_start_q) |-> $past(slot.wr) || $past(slot.wr, 2))
		else $error("start pulse without a command write");
	a_alarm_on_done: assert property ($changed(alarm_q) |-> $past(conv_done))
		else $error("alarm changed without a conversion");
	a_quiet_before_cmd: assert property (s_fresh |-> !ans_q.drive)
		else $error("answer driven before any command");
	a_busy_reads_zero: assert property (s_busy_rd |=> ans_q == 2'b10)
		else $error("busy conversion not answered low");
	a_done_reads_one: assert property (s_done_rd |=> ans_q == 2'b11)
		else $error("finished conversion not answered high");
endmodule

bind swsc_cmd swsc_cmd_properties chk_i (
	.sys_clk(sys_clk), .rst(rst), .slot(slot), .ans_q(ans_q), .conv_start_q(conv_start_q),
	.conv_done(conv_done), .conv_temp(conv_temp), .parasitic_pwr(parasitic_pwr),
	.alarm_q(alarm_q)
);

// ==== verif/swsc_host_model.sv ====
/*
 * bus host model: issues slot events and reads the answer as the pin level.
 * assumes slots are taken on the rising edge of sys_clk.
 */
`timescale 1ns/1ps
module swsc_host_model
	import swsc_pkg::*;
(
	// clock
	input wire logic sys_clk,
	// slot events and answer
	output swsc_slot_t slot,
	input wire swsc_ans_t ans
);
	// ----------------------------------------------------------------
	// slot tasks
	// ----------------------------------------------------------------
	initial slot = '0;
	// one pulse then a free cycle; a released pin reads high by the pull-up
	task automatic cyc(input logic [3:0] s, output logic lvl);
		@(negedge sys_clk);
		slot <= s;
		@(negedge sys_clk);
		slot <= '0;
		lvl = !ans.drive || ans.bit_val;
	endtask
	// every transaction opens with the reset exchange
	task automatic bus_reset;
		logic l;
		cyc(4'h8, l);
	endtask
	task automatic wbit(input logic b);
		logic l;
		cyc({3'b010, b}, l);
	endtask
	// bytes go out whole, lsb first; one device only, so skip then read is safe
	task automatic put(input logic [7:0] b);
		for (int i = 0; i < 8; i++)
			wbit(b[i]);
	endtask
	// normal supply: busy is polled by slots, no strong pull-up needed
	task automatic get(input int n, output logic [71:0] v);
		logic l;
		v = '0;
		for (int i = 0; i < n; i++) begin
			cyc(4'h2, l);
			v[i] = l;
		end
	endtask
endmodule

// ==== verif/swsc_cmd_tb.sv ====
/*
 * self-checking bench of the command layer with a host model and a converter stand-in.
 * assumes a 20 MHz sys_clk and the bound port checker.
 */
`timescale 1ns/1ps
module swsc_cmd_tb;
	import swsc_pkg::*;
	typedef struct packed {
		logic [7:0] rom;
		logic [7:0] fn;
		logic pwr;
		logic [6:0] n;
		logic [71:0] exp;
	} swsc_tb_row_t;
	localparam logic [7:0] FAM = 8'h5a; // arbitrary value
	localparam logic [47:0] SER = 48'h0123_4567_89ab; // arbitrary value
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	swsc_slot_t slot;
	swsc_ans_t ans_q;
	logic conv_start_q;
	logic conv_done;
	logic [15:0] conv_temp;
	logic parasitic_pwr;
	logic alarm_q;
	logic [71:0] v;
	logic [63:0] id;
	swsc_tb_row_t rows [4];
	int n_errors = 0;
	int cmp_count = 0;

	always #25 sys_clk = ~sys_clk;
	swsc_cmd #(.FAMILY_CODE(FAM), .SERIAL_NUM(SER)) DUT (.sys_clk(sys_clk), .rst(rst),
		.slot(slot), .ans_q(ans_q), .conv_start_q(conv_start_q), .conv_done(conv_done),
		.conv_temp(conv_temp), .parasitic_pwr(parasitic_pwr), .alarm_q(alarm_q));
	swsc_host_model HOST (.sys_clk(sys_clk), .slot(slot), .ans(ans_q));
	// converter stand-in: a fixed delay keeps busy polls short; driven off the sampling edge
	initial begin
		conv_done = 1'b0;
		forever begin
			@(negedge sys_clk);
			if (conv_start_q) begin
				repeat (20) @(negedge sys_clk);
				conv_done = 1'b1;
				@(negedge sys_clk);
				conv_done = 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic [7:0] crc8(input logic [71:0] d, input int n);
		logic [7:0] c;
		c = 8'h00;
		for (int i = 0; i < n; i++)
			c = (c >> 1) ^ ((c[0] ^ d[i]) ? 8'h8c : 8'h00);
		return c;
	endfunction
	function automatic logic [71:0] img(input logic [7:0] th, tl, input logic [15:0] t);
		logic [63:0] r;
		r = {8'hff, 8'h00, 8'h00, 8'h7f, tl, th, t};
		return {crc8({8'h00, r}, 64), r};
	endfunction
	task automatic chk(input logic [71:0] got, input logic [71:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_errors++;
			$display("MISMATCH %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic finish_test;
		$display("errors %0d compares %0d", n_errors, cmp_count);
		if (n_errors == 0 && cmp_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic cmd(input logic [7:0] fn);
		HOST.bus_reset();
		HOST.put(8'hcc);
		HOST.put(fn);
	endtask
	task automatic poll;
		int k;
		for (k = 0; k < 400; k++) begin
			HOST.get(1, v);
			if (v[0] === 1'b1)
				break;
		end
		if (k == 400) begin
			n_errors++;
			$display("MISMATCH %0t busy never ended", $time);
			finish_test();
		end
	endtask
	task automatic conv(input logic [15:0] t, input logic al);
		conv_temp = t;
		cmd(8'h44);
		HOST.get(1, v);
		chk(v, 72'h0);
		poll();
		chk(72'(alarm_q), 72'(al));
	endtask
	task automatic srch(input logic [7:0] c, input int n, input logic on);
		HOST.bus_reset();
		HOST.put(c);
		for (int i = 0; i < n; i++) begin
			HOST.get(2, v);
			chk(v, on ? 72'({~id[i], id[i]}) : 72'h3);
			HOST.wbit(id[i]);
		end
	endtask
	task automatic mat(input logic [63:0] m);
		HOST.bus_reset();
		HOST.put(8'h55);
		for (int i = 0; i < 8; i++)
			HOST.put(m[8*i+:8]);
		HOST.put(8'hbe);
		HOST.get(16, v);
	endtask

	// ----------------------------------------------------------------
	// sequence
	// ----------------------------------------------------------------
	initial begin
		conv_temp = 16'h0000;
		parasitic_pwr = 1'b0;
		id = {crc8({16'h0, SER, FAM}, 56), SER, FAM};
		rows[0] = '{8'h33, 8'h00, 1'b0, 7'd64, {8'h00, id}};
		rows[1] = '{8'hcc, 8'hbe, 1'b0, 7'd72, img(8'h55, 8'h00, 16'h0550)};
		rows[2] = '{8'hcc, 8'hb4, 1'b0, 7'd8, 72'hff};
		rows[3] = '{8'hcc, 8'hb4, 1'b1, 7'd8, 72'h00};
		repeat (16) @(negedge sys_clk);
		chk(72'({ans_q, conv_start_q, alarm_q}), 72'h4);
		rst = 1'b0;
		foreach (rows[i]) begin
			parasitic_pwr = rows[i].pwr;
			HOST.bus_reset();
			HOST.put(rows[i].rom);
			if (rows[i].fn !== 8'h00)
				HOST.put(rows[i].fn);
			HOST.get(rows[i].n, v);
			chk(v, rows[i].exp);
		end
		parasitic_pwr = 1'b0;
		HOST.bus_reset();
		HOST.get(2, v);
		chk(v, 72'h3);
		chk(72'(crc8({8'h00, id}, 64)), 72'h0);
		cmd(8'h4e);
		HOST.put(8'h1e);
		HOST.put(8'hf6);
		cmd(8'hbe);
		HOST.get(72, v);
		chk(v, img(8'h1e, 8'hf6, 16'h0550));
		chk(72'(crc8(v, 72)), 72'h0);
		conv(16'h0200, 1'b1);
		cmd(8'hbe);
		HOST.get(16, v);
		chk(v, 72'h0200);
		srch(8'hec, 8, 1'b1);
		srch(8'hf0, 64, 1'b1);
		conv(16'h0190, 1'b0);
		srch(8'hec, 1, 1'b0);
		mat(id);
		chk(v, 72'h0190);
		mat(id ^ 64'h8000_0000_0000_0000);
		chk(v, 72'hffff);
		cmd(8'h12);
		HOST.get(8, v);
		chk(v, 72'hff);
		cmd(8'hbe);
		HOST.get(8, v);
		cmd(8'hb4);
		HOST.get(8, v);
		chk(v, 72'hff);
		cmd(8'h48);
		cmd(8'h4e);
		HOST.put(8'h00);
		HOST.put(8'h00);
		cmd(8'hb8);
		HOST.get(1, v);
		chk(v, 72'h0);
		poll();
		cmd(8'hbe);
		HOST.get(72, v);
		chk(v, img(8'h1e, 8'hf6, 16'h0190));
		cmd(8'hc7);
		cmd(8'hbe);
		HOST.get(72, v);
		chk(v, img(8'h1e, 8'hf6, 16'h0550));
		finish_test();
	end
endmodule
